// file: verification/dcs_link_monitor.sv
`timescale 1ns/100ps
module dcs_link_monitor
  import dcs_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  input  wire logic sclk,
  input  wire logic cs,
  input  wire logic mosi,
  input  wire logic miso,
  input  wire logic miso_oe,
  input  wire logic miso_level
);
  // ------------------------------------------------------------------
  // Frame tracking
  // ------------------------------------------------------------------
  logic        seen;
  logic [15:0] low_cnt;
  logic [15:0] hi_cnt;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !cs) begin
      seen <= 1'h0;
    end else if (sclk) begin
      seen <= 1'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || cs) begin
      low_cnt <= 16'h0000;
    end else if (low_cnt != 16'hFFFF) begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !cs) begin
      hi_cnt <= 16'h0000;
    end else if (hi_cnt != 16'hFFFF) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end
  end

  sequence s_high4;
    sclk [*4];
  endsequence

  sequence s_low4;
    !sclk [*4];
  endsequence

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_OE_CS: assert property (miso_oe == cs)
    else $error("output enable differs from chip select");
  AST_BEF_LEAD: assert property ($rose(cs) |->
    !$past(sclk) && !$past(sclk, 4) ##0 !sclk [*7])
    else $error("clock not low around select rise");
  AST_LAG: assert property ($fell(cs) |->
    !$past(sclk) && !$past(sclk, 7))
    else $error("clock not low before select fall");
  AST_BEH: assert property ($fell(cs) |-> s_low4)
    else $error("clock not low after select fall");
  AST_CSL: assert property ($rose(cs) |-> low_cnt >= CSL_CYC)
    else $error("select low time too short");
  AST_HIGH: assert property ($rose(sclk) |-> s_high4 ##1 !sclk)
    else $error("clock high phase wrong");
  AST_LOW: assert property ($fell(sclk) |-> s_low4)
    else $error("clock low phase too short");
  AST_WAKE: assert property ($rose(sclk) && !seen |->
    hi_cnt >= WAKE_CYC)
    else $error("first clock before wake-up time");
  AST_MOSI_LEAD: assert property (cs && !seen && !sclk |-> !mosi)
    else $error("data out not low before first clock");
  AST_MOSI_HOLD: assert property (sclk && $past(sclk) |->
    $stable(mosi))
    else $error("master data changed in high phase");
  AST_RELEASED: assert property (!miso_oe |-> miso_level)
    else $error("released data line not pulled up");
  AST_MISO_HOLD: assert property (cs && $past(cs) && seen &&
    $stable(sclk) |-> $stable(miso))
    else $error("device data changed away from rise");
endmodule : dcs_link_monitor

// file: verification/tb.sv
`timescale 1ns/100ps
module tb;
  import dcs_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        sys_clk_in  = 1'h0;
  logic        rst_n_in    = 1'h0;
  logic        start       = 1'h0;
  logic [15:0] tx_frame    = 16'h0000;
  logic [15:0] tx_byte     = 16'h0000;
  logic [11:0] faults      = 12'h000;
  logic        ready;
  logic        done;
  logic        m_gef;
  logic        d_gef;
  logic        d_gef_far;
  logic        rx_valid;
  logic        rx_valid_far;
  logic [15:0] rx_frame;
  logic [7:0]  rx_byte;
  logic [7:0]  rx_byte_far;
  int          failures    = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  always #20 sys_clk_in = ~sys_clk_in;

  // Master hop, near hop (watched), far hop
  dcs_link_if m_if ();
  dcs_link_if link_if ();
  dcs_link_if far_if ();

  assign m_if.miso    = far_if.miso_level;
  assign m_if.miso_oe = 1'h1;
  assign link_if.sclk = m_if.sclk;
  assign link_if.cs   = m_if.cs;
  assign link_if.mosi = m_if.mosi;
  assign far_if.sclk  = m_if.sclk;
  assign far_if.cs    = m_if.cs;
  assign far_if.mosi  = link_if.miso_level;

  dcs_master_end #(.CHAIN_LEN(2)) dcs_master_end_i (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(start),
    .tx_frame_in(tx_frame), .ready_out(ready), .done_out(done),
    .global_error_summary_out(m_gef), .rx_frame_out(rx_frame),
    .link(m_if));

  dcs_device_end dcs_device_end_i (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .thermal_a_in(faults[0]), .thermal_b_in(faults[1]),
    .undervoltage_in(faults[2]), .open_load_in(faults[3]),
    .overcurrent_a_in(faults[4]), .overcurrent_b_in(faults[5]),
    .tx_byte_in(tx_byte[7:0]), .rx_byte_out(rx_byte),
    .rx_valid_out(rx_valid), .global_error_summary_out(d_gef),
    .link(link_if));

  dcs_device_end dcs_device_end_far_i (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .thermal_a_in(faults[6]), .thermal_b_in(faults[7]),
    .undervoltage_in(faults[8]), .open_load_in(faults[9]),
    .overcurrent_a_in(faults[10]), .overcurrent_b_in(faults[11]),
    .tx_byte_in(tx_byte[15:8]), .rx_byte_out(rx_byte_far),
    .rx_valid_out(rx_valid_far), .global_error_summary_out(d_gef_far),
    .link(far_if));

  dcs_link_monitor dcs_link_monitor_i (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sclk(link_if.sclk),
    .cs(link_if.cs), .mosi(link_if.mosi), .miso(link_if.miso),
    .miso_oe(link_if.miso_oe), .miso_level(link_if.miso_level));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic give_verdict();
    if (failures == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic run_frame(input logic [15:0] m_tx,
                           input logic [15:0] d_tx,
                           input logic [11:0] flt);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    faults   <= flt;
    tx_byte  <= d_tx;
    tx_frame <= m_tx;
    repeat (4) @(posedge sys_clk_in);
    while (ready !== 1'h1 && n < 300) begin
      @(posedge sys_clk_in);
      n++;
    end
    start <= 1'h1;
    @(posedge sys_clk_in);
    start <= 1'h0;
    n = 0;
    while (done !== 1'h1 && n < 1000) begin
      @(negedge sys_clk_in);
      n++;
    end
    check("done", {7'h00, done}, 8'h01);
    check("ready", {7'h00, ready}, 8'h00);
    check("released", {7'h00, link_if.miso_level}, 8'h01);
    check("released_far", {7'h00, far_if.miso_level}, 8'h01);
    check("rx_near", rx_frame[7:0], d_tx[7:0]);
    check("rx_far", rx_frame[15:8], d_tx[15:8]);
    check("m_gef", {7'h00, m_gef}, {7'h00, |flt});
    check("d_gef", {7'h00, d_gef}, {7'h00, |flt[5:0]});
    check("d_gef_far", {7'h00, d_gef_far}, {7'h00, |flt[11:6]});
    n = 0;
    while (rx_valid !== 1'h1 && n < 10) begin
      @(negedge sys_clk_in);
      n++;
    end
    check("valid_far", {7'h00, rx_valid_far}, 8'h01);
    check("rx_byte", rx_byte, m_tx[7:0]);
    check("rx_byte_far", rx_byte_far, m_tx[15:8]);
  endtask : run_frame

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge sys_clk_in);
    rst_n_in <= 1'h1;
    run_frame(16'h3CC3, 16'hA55A, 12'h000);
    run_frame(16'h8118, 16'h7EE7, 12'h000);
    for (int i = 0; i < 12; i++) begin
      run_frame({8'h11 << (i % 8), 8'h81 >> (i % 8)},
                {8'hC3 >> (i % 8), 8'h3C << (i % 8)},
                12'h001 << i);
    end
    run_frame(16'hFF00, 16'h00FF, 12'hFFF);
    give_verdict();
  end
endmodule : tb

// file: verilog/dcs_device_end.sv
`timescale 1ns/100ps
module dcs_device_end
  import dcs_pkg::*;
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 thermal_a_in,
  input  wire logic                 thermal_b_in,
  input  wire logic                 undervoltage_in,
  input  wire logic                 open_load_in,
  input  wire logic                 overcurrent_a_in,
  input  wire logic                 overcurrent_b_in,
  input  wire logic [BYTE_BITS-1:0] tx_byte_in,
  output logic      [BYTE_BITS-1:0] rx_byte_out,
  output logic                      rx_valid_out,
  output logic                      global_error_summary_out,
  dcs_link_if.device                link
);

  // ------------------------------------------------------------------
  // System domain
  // ------------------------------------------------------------------
  logic                 cs_meta;
  logic                 cs_sync;
  logic                 cs_prev;
  logic [BYTE_BITS-1:0] tx_hold;
  logic                 started;
  logic                 in_bit;
  logic [BYTE_BITS-1:0] shift_reg;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      global_error_summary_out <= 1'h0;
    end else begin
      global_error_summary_out <= thermal_a_in | thermal_b_in |
                                  undervoltage_in | open_load_in |
                                  overcurrent_a_in |
                                  overcurrent_b_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cs_meta <= 1'h0;
      cs_sync <= 1'h0;
      cs_prev <= 1'h0;
    end else begin
      cs_meta <= link.cs;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  // Outgoing byte frozen while a frame runs
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tx_hold <= '0;
    end else if (!cs_sync) begin
      tx_hold <= tx_byte_in;
    end
  end

  // Last eight bits applied at chip select fall
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rx_byte_out  <= '0;
      rx_valid_out <= 1'h0;
    end else begin
      rx_valid_out <= cs_prev & ~cs_sync;
      if (cs_prev && !cs_sync) begin
        rx_byte_out <= {shift_reg[BYTE_BITS-2:0], in_bit};
      end
    end
  end

  // ------------------------------------------------------------------
  // Link domain
  // ------------------------------------------------------------------
  always_ff @(negedge link.sclk) begin
    in_bit <= link.mosi;
  end

  always_ff @(posedge link.sclk or negedge link.cs) begin
    if (!link.cs) begin
      started <= 1'h0;
    end else begin
      started <= 1'h1;
    end
  end

  always_ff @(posedge link.sclk) begin
    if (!started) begin
      shift_reg <= tx_hold;
    end else begin
      shift_reg <= {shift_reg[BYTE_BITS-2:0], in_bit};
    end
  end

  // Error summary ORed with upstream until first rising edge
  assign link.miso    = started ? shift_reg[BYTE_BITS-1]
                      : (global_error_summary_out | link.mosi);
  assign link.miso_oe = link.cs;

endmodule : dcs_device_end

// file: verilog/dcs_link_if.sv
`timescale 1ns/100ps
interface dcs_link_if;

  // ------------------------------------------------------------------
  // Link wires
  // ------------------------------------------------------------------
  logic sclk;
  logic cs;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_level;

  // Pull-up when the data output is released
  assign miso_level = miso_oe ? miso : 1'h1;

  modport device (
    input  sclk,
    input  cs,
    input  mosi,
    output miso,
    output miso_oe
  );

  modport master (
    output sclk,
    output cs,
    output mosi,
    input  miso_level
  );

endinterface : dcs_link_if

// file: verilog/dcs_master_end.sv
`timescale 1ns/100ps

module dcs_master_end
  import dcs_pkg::*;
#(
  parameter int CHAIN_LEN = 1
)
(
  input  wire logic                           sys_clk_in,
  input  wire logic                           rst_n_in,
  input  wire logic                           start_in,
  input  wire logic [BYTE_BITS*CHAIN_LEN-1:0] tx_frame_in,
  output logic                                ready_out,
  output logic                                done_out,
  output logic                                global_error_summary_out,
  output logic      [BYTE_BITS*CHAIN_LEN-1:0] rx_frame_out,
  dcs_link_if.master                          link
);

  // ------------------------------------------------------------------
  // Derived counts
  // ------------------------------------------------------------------
  localparam int FRAME_BITS = BYTE_BITS * CHAIN_LEN;
  localparam int GEF_CYC    =
    dcs_ceil_cycles(T_GEF_PER_DEV_NS * CHAIN_LEN);
  localparam int LEAD_WAIT  =
    dcs_max(dcs_max(WAKE_CYC, GEF_CYC), LEAD_CYC);

  localparam logic [CNT_W-1:0] LEAD_END  = CNT_W'(LEAD_WAIT - 1);
  localparam logic [CNT_W-1:0] HALF_END  = CNT_W'(HALF_CYC - 1);
  localparam logic [CNT_W-1:0] LAG_END   = CNT_W'(LAG_CYC - 1);
  localparam logic [CNT_W-1:0] GAP_END   = CNT_W'(CSL_CYC - 1);
  localparam logic [CNT_W-1:0] BITS_END  = CNT_W'(FRAME_BITS - 1);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  dcs_master_state_type     state;
  dcs_master_state_type     next_state;
  logic [CNT_W-1:0]         cnt;
  logic [CNT_W-1:0]         bit_cnt;
  logic [FRAME_BITS-1:0]    tx_sr;
  logic [FRAME_BITS-1:0]    rx_sr;
  logic                     miso_meta;
  logic                     miso_sync;
  logic                     phase_end;
  logic                     last_bit;

  assign phase_end = (cnt == HALF_END);
  assign last_bit  = (bit_cnt == BITS_END);
  assign ready_out = (state == DCS_IDLE);

  // ------------------------------------------------------------------
  // Input synchroniser
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      miso_meta <= 1'h1;
      miso_sync <= 1'h1;
    end else begin
      miso_meta <= link.miso_level;
      miso_sync <= miso_meta;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      DCS_IDLE: begin
        if (start_in) begin
          next_state = DCS_WAKE;
        end
      end
      DCS_WAKE: begin
        if (cnt == LEAD_END) begin
          next_state = DCS_SHIFT_HI;
        end
      end
      DCS_SHIFT_HI: begin
        if (phase_end) begin
          next_state = DCS_SHIFT_LO;
        end
      end
      DCS_SHIFT_LO: begin
        if (phase_end) begin
          next_state = last_bit ? DCS_LAG : DCS_SHIFT_HI;
        end
      end
      DCS_LAG: begin
        if (cnt == LAG_END) begin
          next_state = DCS_GAP;
        end
      end
      DCS_GAP: begin
        if (cnt == GAP_END) begin
          next_state = DCS_IDLE;
        end
      end
      default: begin
        next_state = DCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state <= DCS_GAP;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
    end else if (next_state != state) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      bit_cnt <= '0;
    end else if (state == DCS_WAKE) begin
      bit_cnt <= '0;
    end else if (state == DCS_SHIFT_LO && phase_end) begin
      bit_cnt <= bit_cnt + CNT_W'(1);
    end
  end

  // ------------------------------------------------------------------
  // Link outputs
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      link.sclk <= 1'h0;
      link.cs   <= 1'h0;
    end else begin
      link.sclk <= (next_state == DCS_SHIFT_HI);
      link.cs   <= (next_state == DCS_WAKE) ||
                   (next_state == DCS_SHIFT_HI) ||
                   (next_state == DCS_SHIFT_LO) ||
                   (next_state == DCS_LAG);
    end
  end

  // Data held low until the first rising edge
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      link.mosi <= 1'h0;
    end else if (next_state == DCS_SHIFT_HI && state == DCS_WAKE) begin
      link.mosi <= tx_sr[FRAME_BITS-1];
    end else if (next_state == DCS_SHIFT_HI && state != DCS_SHIFT_HI) begin
      link.mosi <= tx_sr[FRAME_BITS-2];
    end else if (next_state != DCS_SHIFT_HI &&
                 next_state != DCS_SHIFT_LO) begin
      link.mosi <= 1'h0;
    end
  end

  // Highest slot, farthest device, goes out first
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tx_sr <= '0;
    end else if (state == DCS_IDLE && start_in) begin
      tx_sr <= tx_frame_in;
    end else if (state == DCS_SHIFT_LO && phase_end) begin
      tx_sr <= {tx_sr[FRAME_BITS-2:0], 1'h0};
    end
  end

  // ------------------------------------------------------------------
  // Return path
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rx_sr <= '0;
    end else if (state == DCS_SHIFT_LO && phase_end) begin
      rx_sr <= {rx_sr[FRAME_BITS-2:0], miso_sync};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      global_error_summary_out <= 1'h0;
    end else if (state == DCS_WAKE && cnt == LEAD_END) begin
      global_error_summary_out <= miso_sync;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rx_frame_out <= '0;
      done_out     <= 1'h0;
    end else begin
      done_out <= (state == DCS_LAG) && (cnt == LAG_END);
      if (state == DCS_LAG && cnt == LAG_END) begin
        rx_frame_out <= rx_sr;
      end
    end
  end

endmodule : dcs_master_end

// file: verilog/dcs_pkg.sv
package dcs_pkg;

  // ------------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------------
  localparam int BYTE_BITS          = 8;
  localparam int CNT_W              = 16;

  // ------------------------------------------------------------------
  // Timing figures in ns
  // ------------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS  = 40;
  localparam int T_BEF_NS           = 125;
  localparam int T_LEAD_NS          = 250;
  localparam int T_LAG_NS           = 250;
  localparam int T_BEH_NS           = 125;
  localparam int T_PCLK_MIN_NS      = 250;
  localparam int T_WAKEUP_NS        = 20000;
  localparam int T_CSL_NS           = 4000;
  localparam int T_GEF_PER_DEV_NS   = 250;

  // Least time to whole cycles, never below one
  function automatic int dcs_ceil_cycles(input int ns);
    int c;
    c = (ns + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : dcs_ceil_cycles

  function automatic int dcs_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : dcs_max

  // ------------------------------------------------------------------
  // Timing counts in sys_clk cycles
  // ------------------------------------------------------------------
  localparam int HALF_CYC  = dcs_ceil_cycles(T_PCLK_MIN_NS / 2);
  localparam int BEF_CYC   = dcs_ceil_cycles(T_BEF_NS);
  localparam int LEAD_CYC  = dcs_ceil_cycles(T_LEAD_NS);
  localparam int LAG_CYC   = dcs_ceil_cycles(T_LAG_NS);
  localparam int BEH_CYC   = dcs_ceil_cycles(T_BEH_NS);
  localparam int WAKE_CYC  = dcs_ceil_cycles(T_WAKEUP_NS);
  localparam int CSL_CYC   = dcs_max(dcs_ceil_cycles(T_CSL_NS),
                                     BEH_CYC + BEF_CYC);

  // ------------------------------------------------------------------
  // Master sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    DCS_IDLE     = 3'h0,
    DCS_WAKE     = 3'h1,
    DCS_SHIFT_HI = 3'h2,
    DCS_SHIFT_LO = 3'h3,
    DCS_LAG      = 3'h4,
    DCS_GAP      = 3'h5
  } dcs_master_state_type;

endpackage : dcs_pkg
